/* bmvcd_pkg.sv */
package bmvcd_pkg;

	// signature words, first byte read from address 0x00 in the upper half
	localparam logic [15:0] SIG_NORMAL = 16'h534b;
	localparam logic [15:0] SIG_LEGACY = 16'h4d4d;
	// vendor subcommand codes in command block byte 1
	localparam logic [7:0] SUB_CFG = 8'h26;
	localparam logic [7:0] SUB_MFG = 8'h27;
	// data source code selecting the eeprom
	localparam logic [7:0] SRC_EEPROM = 8'h02;
	// largest configuration transfer in bytes
	localparam logic [31:0] MAX_XFER = 32'h0000_00ff;
	// direction flag position in the wrapper flags byte
	localparam int DIR_BIT = 7;
	// data bit of byte 1 that enables the drive data bus
	localparam int DD_OE_BIT = 7;
	// pin load bytes that reach pins
	localparam logic [2:0] PIN_BYTES = 3'h4;
	// cycles the strap synchroniser settles before the probe
	localparam logic [2:0] STRAP_SETTLE = 3'h4;
	// reset values
	localparam logic RST_STRAP = 1'b1;
	localparam logic [7:0] RST_DESIG = 8'h24;

	typedef enum logic [2:0] {
		BOOT_SETTLE = 3'b001,
		BOOT_WAIT = 3'b010,
		BOOT_RUN = 3'b100
	} bmvcd_boot_t;

	typedef enum logic [2:0] {
		MODE_NORMAL = 3'b001,
		MODE_LEGACY = 3'b010,
		MODE_TEST = 3'b100
	} bmvcd_mode_t;

	typedef enum logic [2:0] {
		DSC_EEPROM = 3'b001,
		DSC_FUSE = 3'b010,
		DSC_BUILTIN = 3'b100
	} bmvcd_src_t;

	// one command wrapper: block bytes, transfer length, direction flag
	typedef struct packed {
		logic [127:0] cb;
		logic [31:0] len;
		logic [7:0] flags;
	} bmvcd_cbw_t;

	// result of the eeprom probe
	typedef struct packed {
		logic done;
		logic ack;
		logic [15:0] sig;
		logic [7:0] desig;
	} bmvcd_probe_t;

	typedef struct packed {
		logic [2:0] strap_sync;
		logic strap_level;
		bmvcd_boot_t boot;
		logic [2:0] settle;
		bmvcd_mode_t mode;
		bmvcd_src_t src;
		logic [7:0] designator;
		logic probe_start;
		logic cmd_done;
		logic cmd_fail;
		logic cmd_pass;
		logic ee_start;
		logic ee_write;
		logic [7:0] ee_len;
		logic pin_ovr;
		logic dd_oe;
		logic [31:0] pin_bytes;
		logic loading;
		logic [2:0] load_idx;
		logic [31:0] load_left;
	} bmvcd_state_t;

	localparam bmvcd_state_t RST_STATE = '{
		strap_sync: {3{RST_STRAP}},
		strap_level: RST_STRAP,
		boot: BOOT_SETTLE,
		mode: MODE_NORMAL,
		src: DSC_BUILTIN,
		designator: RST_DESIG,
		default: '0
	};

endpackage : bmvcd_pkg

/* bmvcd_decoder.sv */
// Notes on behaviour
// - probe eeprom, pick pinout, sample strap
// - no eeprom answer: use fused values
// - signature 0x4D4D: legacy pinout and layout
// - signature 0x534B: eeprom descriptors, normal mode
// - unknown signature: manufacturing test mode
// - no eeprom, fuses zero: test, builtin
// - normal mode descriptors from eeprom or fuses
// - test mode: partial drive, vendor commands served
// - strap low at power-up forces test
// - byte 0 must match vendor designator
// - subcommand 0x26 means configuration access
// - configuration transfer at most 255 bytes
// - length from wrapper, direction from flag bit
// - subcommand 0x27, zero tail: pin test
// - pin load enters test, overrides pins
// - only first four load bytes drive pins
// - test mode ends only on reset
// - byte 1 bit 7 enables data bus
// - normal signature 0x53 then companion byte
`timescale 1ns/1ps

module bmvcd_decoder #(
	parameter int FUSE_W = 48
) (
	// clock and reset
	input wire logic core_clk,
	input wire logic rst_b,
	// power-up sources
	input wire logic drive_reset_strap,
	input wire bmvcd_pkg::bmvcd_probe_t probe,
	input wire logic [FUSE_W-1:0] fuse_data,
	// command wrapper from the bulk pipe
	input wire logic cbw_valid,
	input wire bmvcd_pkg::bmvcd_cbw_t cbw,
	// host data stream for a pin load
	input wire logic data_valid,
	input wire logic [7:0] data_byte,
	// mode outputs
	output logic probe_start,
	output bmvcd_pkg::bmvcd_mode_t op_mode,
	output bmvcd_pkg::bmvcd_src_t desc_src,
	// command result
	output logic cmd_done,
	output logic cmd_fail,
	output logic cmd_pass,
	output logic cmd_busy,
	// eeprom transfer request
	output logic ee_start,
	output logic ee_write,
	output logic [7:0] ee_len,
	// manufacturing pin control
	output logic pin_ovr,
	output logic dd_oe,
	output logic [31:0] pin_bytes
);

	generate
		if (FUSE_W < 1) begin : g_bad_fuse
			$error("fuse width must be at least one bit");
		end
	endgenerate

	bmvcd_pkg::bmvcd_state_t st;
	bmvcd_pkg::bmvcd_state_t next_st;
	logic accept;
	logic cfg_ok;
	logic mfg_ok;
	logic is_test;
	logic dir_in;

	// decode helpers for the incoming wrapper
	always_comb begin
		accept = cbw_valid && (st.boot == bmvcd_pkg::BOOT_RUN) && !st.loading;
		is_test = (st.mode == bmvcd_pkg::MODE_TEST);
		dir_in = cbw.flags[bmvcd_pkg::DIR_BIT];
		cfg_ok = (cbw.cb[23:16] == 8'h00)
			&& (cbw.cb[31:24] == bmvcd_pkg::SRC_EEPROM)
			&& (cbw.cb[47:32] == 16'h0000)
			&& (cbw.cb[127:48] == 80'h0)
			&& (cbw.len <= bmvcd_pkg::MAX_XFER);
		mfg_ok = (cbw.cb[127:16] == 112'h0);
	end

	// next state of the whole block
	always_comb begin
		next_st = st;
		next_st.probe_start = 1'b0;
		next_st.cmd_done = 1'b0;
		next_st.cmd_fail = 1'b0;
		next_st.cmd_pass = 1'b0;
		next_st.ee_start = 1'b0;
		// strap synchroniser, level moves when stages two and three agree
		next_st.strap_sync = {st.strap_sync[1:0], drive_reset_strap};
		if (st.strap_sync[1] == st.strap_sync[2]) begin
			next_st.strap_level = st.strap_sync[2];
		end
		case (st.boot)
			bmvcd_pkg::BOOT_SETTLE: begin
				// let the strap settle, then start the probe
				next_st.settle = st.settle + 3'h1;
				if (st.settle == bmvcd_pkg::STRAP_SETTLE - 3'h1) begin
					next_st.probe_start = 1'b1;
					next_st.boot = bmvcd_pkg::BOOT_WAIT;
				end
			end
			bmvcd_pkg::BOOT_WAIT: begin
				if (probe.done) begin
					next_st.boot = bmvcd_pkg::BOOT_RUN;
					if (!probe.ack) begin
						if (fuse_data == '0) begin
							next_st.mode = bmvcd_pkg::MODE_TEST;
							next_st.src = bmvcd_pkg::DSC_BUILTIN;
						end else begin
							next_st.mode = bmvcd_pkg::MODE_NORMAL;
							next_st.src = bmvcd_pkg::DSC_FUSE;
						end
					end else if (probe.sig == bmvcd_pkg::SIG_NORMAL) begin
						next_st.mode = bmvcd_pkg::MODE_NORMAL;
						next_st.src = bmvcd_pkg::DSC_EEPROM;
						next_st.designator = probe.desig;
					end else if (probe.sig == bmvcd_pkg::SIG_LEGACY) begin
						next_st.mode = bmvcd_pkg::MODE_LEGACY;
						next_st.src = bmvcd_pkg::DSC_EEPROM;
					end else begin
						next_st.mode = bmvcd_pkg::MODE_TEST;
						next_st.src = bmvcd_pkg::DSC_BUILTIN;
					end
					// strap low overrides the mode whatever the eeprom says
					if (!st.strap_level) begin
						next_st.mode = bmvcd_pkg::MODE_TEST;
					end
				end
			end
			bmvcd_pkg::BOOT_RUN: begin
				if (st.loading) begin
					// pin load data, only the first bytes reach pins
					if (data_valid) begin
						if (st.load_idx < bmvcd_pkg::PIN_BYTES) begin
							next_st.pin_bytes[{st.load_idx[1:0], 3'h0} +: 8] =
								data_byte;
							next_st.load_idx = st.load_idx + 3'h1;
						end
						if (st.load_idx == 3'h1) begin
							next_st.dd_oe = data_byte[bmvcd_pkg::DD_OE_BIT];
						end
						next_st.load_left = st.load_left - 32'h1;
						if (st.load_left == 32'h1) begin
							next_st.loading = 1'b0;
						end
					end
				end else if (accept) begin
					if (cbw.cb[7:0] != st.designator) begin
						// not a vendor block, hand it on untouched
						next_st.cmd_pass = 1'b1;
					end else begin
						next_st.cmd_done = 1'b1;
						case (cbw.cb[15:8])
							bmvcd_pkg::SUB_CFG: begin
								if (!cfg_ok || !is_test) begin
									next_st.cmd_fail = 1'b1;
								end else begin
									next_st.ee_start = 1'b1;
									next_st.ee_write = !dir_in;
									next_st.ee_len = cbw.len[7:0];
								end
							end
							bmvcd_pkg::SUB_MFG: begin
								if (!mfg_ok) begin
									next_st.cmd_fail = 1'b1;
								end else if (!dir_in) begin
									// pin load takes the pins over
									next_st.mode = bmvcd_pkg::MODE_TEST;
									next_st.pin_ovr = 1'b1;
									next_st.load_idx = 3'h0;
									next_st.load_left = cbw.len;
									next_st.loading = (cbw.len != 32'h0);
								end else if (!is_test) begin
									next_st.cmd_fail = 1'b1;
								end
							end
							default: begin
								next_st.cmd_fail = 1'b1;
							end
						endcase
					end
				end
			end
			default: begin
				next_st.boot = bmvcd_pkg::BOOT_SETTLE;
			end
		endcase
		// once in test mode nothing but reset leaves it
		if (is_test) begin
			next_st.mode = bmvcd_pkg::MODE_TEST;
		end
	end

	// all state in one register
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			st <= bmvcd_pkg::RST_STATE;
		end else begin
			st <= next_st;
		end
	end

	// outputs straight from the state register
	assign probe_start = st.probe_start;
	assign op_mode = st.mode;
	assign desc_src = st.src;
	assign cmd_done = st.cmd_done;
	assign cmd_fail = st.cmd_fail;
	assign cmd_pass = st.cmd_pass;
	assign cmd_busy = st.loading;
	assign ee_start = st.ee_start;
	assign ee_write = st.ee_write;
	assign ee_len = st.ee_len;
	assign pin_ovr = st.pin_ovr;
	assign dd_oe = st.dd_oe;
	assign pin_bytes = st.pin_bytes;

	// checks
	AST_PROBE_AFTER_SETTLE: assert property (
		@(posedge core_clk) disable iff (!rst_b)
		$rose(st.probe_start) |-> $past(st.boot) == bmvcd_pkg::BOOT_SETTLE
			##1 st.boot == bmvcd_pkg::BOOT_WAIT)
		else $error("probe started outside settle");
	AST_NO_EE_FUSE: assert property (
		@(posedge core_clk) disable iff (!rst_b)
		st.boot == bmvcd_pkg::BOOT_WAIT && probe.done && !probe.ack
			&& fuse_data != '0 |=> st.src == bmvcd_pkg::DSC_FUSE)
		else $error("fused values not chosen");
	AST_SIG_LEGACY: assert property (
		@(posedge core_clk) disable iff (!rst_b)
		st.boot == bmvcd_pkg::BOOT_WAIT && probe.done && probe.ack
			&& probe.sig == bmvcd_pkg::SIG_LEGACY && st.strap_level
			|=> st.mode == bmvcd_pkg::MODE_LEGACY)
		else $error("legacy signature not honoured");
	AST_SIG_NORMAL: assert property (
		@(posedge core_clk) disable iff (!rst_b)
		st.boot == bmvcd_pkg::BOOT_WAIT && probe.done && probe.ack
			&& probe.sig == bmvcd_pkg::SIG_NORMAL && st.strap_level
			|=> st.mode == bmvcd_pkg::MODE_NORMAL
			&& st.src == bmvcd_pkg::DSC_EEPROM)
		else $error("normal signature not honoured");
	AST_BAD_SIG: assert property (
		@(posedge core_clk) disable iff (!rst_b)
		st.boot == bmvcd_pkg::BOOT_WAIT && probe.done && probe.ack
			&& probe.sig != bmvcd_pkg::SIG_NORMAL
			&& probe.sig != bmvcd_pkg::SIG_LEGACY
			|=> st.mode == bmvcd_pkg::MODE_TEST)
		else $error("bad signature did not force test mode");
	AST_BLANK_FUSE: assert property (
		@(posedge core_clk) disable iff (!rst_b)
		st.boot == bmvcd_pkg::BOOT_WAIT && probe.done && !probe.ack
			&& fuse_data == '0 |=> st.mode == bmvcd_pkg::MODE_TEST
			&& st.src == bmvcd_pkg::DSC_BUILTIN)
		else $error("blank fuses not handled");
	AST_STRAP_TEST: assert property (
		@(posedge core_clk) disable iff (!rst_b)
		st.boot == bmvcd_pkg::BOOT_WAIT && probe.done && !st.strap_level
			|=> st.mode == bmvcd_pkg::MODE_TEST)
		else $error("strap low did not force test mode");
	AST_TEST_STICKY: assert property (
		@(posedge core_clk) disable iff (!rst_b)
		st.mode == bmvcd_pkg::MODE_TEST |=> st.mode == bmvcd_pkg::MODE_TEST)
		else $error("test mode left without reset");
	AST_FOREIGN_BLOCK: assert property (
		@(posedge core_clk) disable iff (!rst_b)
		accept && cbw.cb[7:0] != st.designator
			|=> st.cmd_pass && !st.cmd_done && !st.ee_start)
		else $error("foreign block decoded as vendor");
	AST_CFG_LIMIT: assert property (
		@(posedge core_clk) disable iff (!rst_b)
		accept && cbw.cb[7:0] == st.designator
			&& cbw.cb[15:8] == bmvcd_pkg::SUB_CFG
			&& cbw.len > bmvcd_pkg::MAX_XFER |=> st.cmd_fail && !st.ee_start)
		else $error("oversize transfer not failed");
	AST_CFG_DIR: assert property (
		@(posedge core_clk) disable iff (!rst_b)
		st.ee_start |-> st.ee_write == !$past(dir_in)
			&& st.ee_len == $past(cbw.len[7:0]))
		else $error("transfer direction or length wrong");
	AST_RESERVED_FAIL: assert property (
		@(posedge core_clk) disable iff (!rst_b)
		accept && cbw.cb[7:0] == st.designator
			&& cbw.cb[15:8] == bmvcd_pkg::SUB_CFG && !cfg_ok
			|=> st.cmd_fail && st.cmd_done && !st.ee_start)
		else $error("malformed block not failed");
	AST_LOAD_TAKEOVER: assert property (
		@(posedge core_clk) disable iff (!rst_b)
		accept && cbw.cb[7:0] == st.designator
			&& cbw.cb[15:8] == bmvcd_pkg::SUB_MFG && mfg_ok && !dir_in
			|=> st.pin_ovr && st.mode == bmvcd_pkg::MODE_TEST)
		else $error("pin load did not take the pins");
	AST_DD_ENABLE: assert property (
		@(posedge core_clk) disable iff (!rst_b)
		st.loading && data_valid && st.load_idx == 3'h1
			|=> st.dd_oe == $past(data_byte[bmvcd_pkg::DD_OE_BIT]))
		else $error("data bus enable not loaded");
	AST_PIN_FOUR: assert property (
		@(posedge core_clk) disable iff (!rst_b)
		st.loading && st.load_idx == bmvcd_pkg::PIN_BYTES
			|=> $stable(st.pin_bytes))
		else $error("byte beyond four reached the pins");

endmodule : bmvcd_decoder

/* bmvcd_probe_model.sv */
`timescale 1ns/1ps

module bmvcd_probe_model (
	// clock and reset
	input wire logic core_clk,
	input wire logic rst_b,
	// probe request and eeprom contents
	input wire logic probe_start,
	input wire logic ack,
	input wire logic [15:0] sig,
	input wire logic [7:0] desig,
	// probe answer
	output bmvcd_pkg::bmvcd_probe_t probe
);
	int cnt;

	// answers five cycles after the request, scrambled lines otherwise
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			cnt <= 0;
			probe <= '0;
		end else begin
			if (cnt == 1) begin
				probe <= '{1'b1, ack, sig, desig};
				cnt <= 0;
			end else begin
				// idle lines show the inverse of their last value
				probe <= '{1'b0, ~probe.ack, ~probe.sig, ~probe.desig};
				if (probe_start) begin
					cnt <= 5;
				end else if (cnt > 1) begin
					cnt <= cnt - 1;
				end
			end
		end
	end

endmodule : bmvcd_probe_model

/* boot_mode_and_vendor_cmd_decoder_tb_top.sv */
`timescale 1ns/1ps

module boot_mode_and_vendor_cmd_decoder_tb_top;
	// design inputs and partner contents
	logic core_clk = 0;
	logic rst_b = 0;
	logic drive_reset_strap = 1;
	logic cbw_valid = 0;
	logic data_valid = 0;
	logic [7:0] data_byte = '0;
	logic [47:0] fuse_data = '0;
	logic m_ack = 0;
	logic [15:0] m_sig = '0;
	logic [7:0] m_dsg = '0;
	bmvcd_pkg::bmvcd_cbw_t cbw = '0;
	// design outputs
	bmvcd_pkg::bmvcd_probe_t probe;
	bmvcd_pkg::bmvcd_mode_t op_mode;
	bmvcd_pkg::bmvcd_src_t desc_src;
	logic probe_start, cmd_done, cmd_fail, cmd_pass, cmd_busy;
	logic ee_start, ee_write, pin_ovr, dd_oe;
	logic [7:0] ee_len;
	logic [31:0] pin_bytes;
	// bench state
	int n_mismatch = 0;
	int n_tests = 0;
	int cyc = 0;
	int seed = 32'ha6cc1157;
	int i;
	logic [7:0] dsg;
	logic [127:0] cb;
	logic [31:0] len;

	always #4 core_clk = ~core_clk;

	bmvcd_decoder #(.FUSE_W(48)) bmvcd_decoder_i (.core_clk, .rst_b,
		.drive_reset_strap, .probe, .fuse_data, .cbw_valid, .cbw,
		.data_valid, .data_byte, .probe_start, .op_mode, .desc_src,
		.cmd_done, .cmd_fail, .cmd_pass, .cmd_busy, .ee_start, .ee_write,
		.ee_len, .pin_ovr, .dd_oe, .pin_bytes);

	bmvcd_probe_model bmvcd_probe_model_i (.core_clk, .rst_b, .probe_start,
		.ack(m_ack), .sig(m_sig), .desig(m_dsg), .probe);

	task end_of_test;
		$display("tests %0d mismatches %0d", n_tests, n_mismatch);
		if (n_mismatch == 0 && n_tests > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : end_of_test

	task chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			n_mismatch++;
			$display("BAD %0t value %h expected %h", $time, got, exp);
		end
	endtask : chk

	task chk_mode(input bmvcd_pkg::bmvcd_mode_t got,
		input bmvcd_pkg::bmvcd_mode_t exp);
		n_tests++;
		if (got !== exp) begin
			n_mismatch++;
			$display("BAD %0t mode %b expected %b", $time, got, exp);
		end
	endtask : chk_mode

	// expected mode from strap, probe answer, signature and fuses
	function automatic bmvcd_pkg::bmvcd_mode_t exp_mode(input logic s, a,
		input logic [15:0] g, input logic [47:0] f);
		if (!s || (!a && f == '0))
			return bmvcd_pkg::MODE_TEST;
		if (!a || g == bmvcd_pkg::SIG_NORMAL)
			return bmvcd_pkg::MODE_NORMAL;
		if (g == bmvcd_pkg::SIG_LEGACY)
			return bmvcd_pkg::MODE_LEGACY;
		return bmvcd_pkg::MODE_TEST;
	endfunction : exp_mode

	// expected descriptor source from probe answer, signature and fuses
	function automatic logic [2:0] exp_src(input logic a,
		input logic [15:0] g, input logic [47:0] f);
		if (!a)
			return f == '0 ? bmvcd_pkg::DSC_BUILTIN : bmvcd_pkg::DSC_FUSE;
		if (g == bmvcd_pkg::SIG_NORMAL || g == bmvcd_pkg::SIG_LEGACY)
			return bmvcd_pkg::DSC_EEPROM;
		return bmvcd_pkg::DSC_BUILTIN;
	endfunction : exp_src

	function automatic logic [127:0] mk(input logic [7:0] d, u, b2, b3,
		input logic [15:0] a, input logic [79:0] t);
		return {t, a, b3, b2, u, d};
	endfunction : mk

	function automatic logic [127:0] cfg(input logic [7:0] d);
		return mk(d, bmvcd_pkg::SUB_CFG, 0, bmvcd_pkg::SRC_EEPROM, 0, 0);
	endfunction : cfg

	// reset, release and wait for the probe answer
	task boot(input logic s, a, input logic [15:0] g, input logic [47:0] f);
		rst_b <= 0;
		drive_reset_strap <= s;
		m_ack <= a;
		m_sig <= g;
		m_dsg <= dsg;
		fuse_data <= f;
		repeat (20) @(posedge core_clk);
		chk_mode(op_mode, bmvcd_pkg::MODE_NORMAL);
		chk({pin_ovr, dd_oe, cmd_busy, desc_src}, 6'h04);
		rst_b <= 1;
		repeat (4) @(posedge core_clk);
		#1 chk(probe_start, 1'b1);
		for (int k = 0; k < 50 && probe.done !== 1'b1; k++)
			@(posedge core_clk) #1;
		@(posedge core_clk) #1;
		chk_mode(op_mode, exp_mode(s, a, g, f));
		chk(desc_src, exp_src(a, g, f));
	endtask : boot

	task cmd(input logic [127:0] c, input logic [31:0] l, input logic [7:0] f);
		@(posedge core_clk);
		cbw_valid <= 1;
		cbw <= '{cb: c, len: l, flags: f};
		@(posedge core_clk);
		cbw_valid <= 0;
		#1;
	endtask : cmd

	// pin load with n data bytes streamed back to back
	task load(input logic [7:0] d, input int n);
		logic [7:0] b [6];
		cmd(mk(d, bmvcd_pkg::SUB_MFG, 0, 0, 0, 0), n, 8'h00);
		chk({cmd_done, pin_ovr, cmd_busy}, 3'b111);
		chk_mode(op_mode, bmvcd_pkg::MODE_TEST);
		for (int k = 0; k < n; k++) begin
			@(posedge core_clk);
			b[k] = $random(seed);
			data_valid <= 1;
			data_byte <= b[k];
		end
		@(posedge core_clk);
		data_valid <= 0;
		repeat (2) @(posedge core_clk);
		#1 chk(pin_bytes, {b[3], b[2], b[1], b[0]});
		chk({dd_oe, cmd_busy}, {b[1][bmvcd_pkg::DD_OE_BIT], 1'b0});
	endtask : load

	// hang guard
	always @(posedge core_clk) begin
		cyc <= cyc + 1;
		if (cyc == 3000) begin
			n_mismatch++;
			end_of_test;
		end
	end

	initial begin
		dsg = $random(seed);
		if (dsg == bmvcd_pkg::RST_DESIG)
			dsg = 8'h5a;
		boot(1, 1, bmvcd_pkg::SIG_NORMAL, 48'h0);
		cmd(cfg(bmvcd_pkg::RST_DESIG), 16, 8'h80);
		chk({cmd_done, cmd_fail, cmd_pass, ee_start}, 4'b0010);
		cmd(cfg(dsg), 16, 8'h80);
		chk({cmd_done, cmd_fail, cmd_pass, ee_start}, 4'b1100);
		cmd(mk(dsg, bmvcd_pkg::SUB_MFG, 0, 0, 0, 80'h1), 4, 8'h00);
		chk({cmd_done, cmd_fail, cmd_pass, ee_start}, 4'b1100);
		// pin read outside test mode is refused
		cmd(mk(dsg, bmvcd_pkg::SUB_MFG, 0, 0, 0, 0), 4, 8'h80);
		chk({cmd_done, cmd_fail, cmd_pass, ee_start}, 4'b1100);
		load(dsg, 6);
		// pin read inside test mode is served
		cmd(mk(dsg, bmvcd_pkg::SUB_MFG, 0, 0, 0, 0), 4, 8'h80);
		chk({cmd_done, cmd_fail, cmd_pass, ee_start}, 4'b1000);
		len = $random(seed) & 32'hff;
		cmd(cfg(dsg), len, 8'h80);
		chk({cmd_done, cmd_fail, cmd_pass, ee_start}, 4'b1001);
		chk({ee_write, ee_len}, {1'b0, len[7:0]});
		chk_mode(op_mode, bmvcd_pkg::MODE_TEST);
		boot(1, 1, bmvcd_pkg::SIG_LEGACY, 48'h0);
		boot(1, 1, 16'h1234, 48'h0);
		boot(1, 0, 16'h1234, {$random(seed), 16'h1});
		boot(0, 1, bmvcd_pkg::SIG_NORMAL, 48'h0);
		boot(1, 0, 16'h0, 48'h0);
		cmd(cfg(bmvcd_pkg::RST_DESIG), 255, 8'h00);
		chk({cmd_done, cmd_fail, cmd_pass, ee_start}, 4'b1001);
		chk({ee_write, ee_len}, 9'h1ff);
		for (i = 0; i < 6; i++) begin
			cb = cfg(bmvcd_pkg::RST_DESIG);
			len = 16;
			case (i)
				0: cb[23:16] = 8'h01;
				1: cb[31:24] = 8'h01;
				2: cb[39:32] = 8'h01;
				3: cb[127:120] = 8'h01;
				4: len = 256;
				default: cb[15:8] = 8'h28;
			endcase
			cmd(cb, len, 8'h80);
			chk({cmd_done, cmd_fail, cmd_pass, ee_start}, 4'b1100);
		end
		end_of_test;
	end

endmodule : boot_mode_and_vendor_cmd_decoder_tb_top
